// ### rtl/ccir_consts.vh
// Purpose: register map, field positions and reset values of the conversion config block
// Assumes: 16-bit registers on an 8-bit pointer, reached over the two-wire register port
// Notes: definitions only
`ifndef CCIR_CONSTS_VH
`define CCIR_CONSTS_VH

`define CCIR_ADDR_STATUS      8'h18
`define CCIR_ADDR_FAULT       8'h19
`define CCIR_ADDR_CONFIG      8'h1A
`define CCIR_ADDR_SCAN        8'h1B

`define CCIR_RST_FAULT        16'h0000
`define CCIR_RST_CONFIG       16'h2801
`define CCIR_RST_SCAN         16'h020F

`define CCIR_ST_CHAN_HI       15
`define CCIR_ST_CHAN_LO       14
`define CCIR_ST_TIMEOUT       11
`define CCIR_ST_READY         6

`define CCIR_FR_TO_WORD       13
`define CCIR_FR_AH_WORD       12
`define CCIR_FR_AL_WORD       11
`define CCIR_FR_TO_IRQ        5
`define CCIR_FR_RDY_IRQ       0

`define CCIR_CF_CHAN_HI       15
`define CCIR_CF_CHAN_LO       14
`define CCIR_CF_SLEEP         13
`define CCIR_CF_ACT_MODE      11
`define CCIR_CF_REF_SRC       9
`define CCIR_CF_IRQ_OFF       7
`define CCIR_CF_BOOST         6

`define CCIR_SC_SCAN_ON       15
`define CCIR_SC_LIST_HI       14
`define CCIR_SC_LIST_LO       13

`define CCIR_RW_TIMEOUT       13
`define CCIR_RW_AMP           12

`endif

// ### rtl/ccir_i2c_slave.v
// Purpose: two-wire register port, pointer plus 16-bit word transfers
// Assumes: bus pins arrive asynchronously; bus clock far below clk
// Notes: no clock stretching; pointer does not auto-increment
`timescale 1ns/1ps
`default_nettype none
module ccir_i2c_slave #(
   parameter [6:0] DEV_ADDR = 7'h20
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        scl_i,
   input  wire        sda_i,
   output reg         sda_oe,
   output reg  [7:0]  ptr,
   output reg         wr_stb,
   output reg  [15:0] wr_data,
   output reg         rd_stb,
   input  wire [15:0] rd_data
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_RX   = 5'h02;
   localparam [4:0] S_ACK  = 5'h04;
   localparam [4:0] S_TX   = 5'h08;
   localparam [4:0] S_RACK = 5'h10;

   reg  [2:0]  scl_sync_reg;
   reg  [2:0]  sda_sync_reg;
   reg  [4:0]  state_reg;
   reg  [1:0]  phase_reg;
   reg         rw_reg;
   reg         tx_byte_reg;
   reg         mack_reg;
   reg  [3:0]  bitc_reg;
   reg  [7:0]  sh_reg;
   reg  [7:0]  hi_reg;
   reg  [15:0] tx_reg;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_c;
   wire        stop_c;

   // stage 0 only feeds stage 1; edges use stages 1 and 2
   assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
   assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
   assign start_c  = scl_sync_reg[1] & ~sda_sync_reg[1] & sda_sync_reg[2];
   assign stop_c   = scl_sync_reg[1] & sda_sync_reg[1] & ~sda_sync_reg[2];

   always @(posedge clk) begin
      if (rst) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         state_reg    <= S_IDLE;
         phase_reg    <= 2'h0;
         rw_reg       <= 1'b0;
         tx_byte_reg  <= 1'b0;
         mack_reg     <= 1'b0;
         bitc_reg     <= 4'h0;
         sh_reg       <= 8'h00;
         hi_reg       <= 8'h00;
         tx_reg       <= 16'h0000;
         sda_oe       <= 1'b0;
         ptr          <= 8'h00;
         wr_stb       <= 1'b0;
         wr_data      <= 16'h0000;
         rd_stb       <= 1'b0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
         wr_stb       <= 1'b0;
         rd_stb       <= 1'b0;
         if (start_c) begin
            state_reg <= S_RX;
            phase_reg <= 2'h0;
            bitc_reg  <= 4'h0;
            sda_oe    <= 1'b0;
         end else if (stop_c) begin
            state_reg <= S_IDLE;
            sda_oe    <= 1'b0;
         end else begin
            case (state_reg)
               S_IDLE: begin
                  sda_oe <= 1'b0;
               end
               S_RX: begin
                  if (scl_rise) begin
                     sh_reg   <= {sh_reg[6:0], sda_sync_reg[1]};
                     bitc_reg <= bitc_reg + 4'h1;
                  end else if (scl_fall && bitc_reg == 4'h8) begin
                     state_reg <= S_ACK;
                     sda_oe    <= 1'b1;
                     case (phase_reg)
                        2'h0: begin
                           if (sh_reg[7:1] == DEV_ADDR) begin
                              rw_reg    <= sh_reg[0];
                              phase_reg <= 2'h1;
                              if (sh_reg[0]) begin
                                 tx_reg      <= rd_data;
                                 tx_byte_reg <= 1'b0;
                                 rd_stb      <= 1'b1;
                              end
                           end else begin
                              state_reg <= S_IDLE;
                              sda_oe    <= 1'b0;
                           end
                        end
                        2'h1: begin
                           ptr       <= sh_reg;
                           phase_reg <= 2'h2;
                        end
                        2'h2: begin
                           hi_reg    <= sh_reg;
                           phase_reg <= 2'h3;
                        end
                        default: begin
                           wr_data   <= {hi_reg, sh_reg};
                           wr_stb    <= 1'b1;
                           phase_reg <= 2'h2;
                        end
                     endcase
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     bitc_reg <= 4'h0;
                     if (rw_reg) begin
                        state_reg <= S_TX;
                        sda_oe    <= ~tx_reg[15];
                     end else begin
                        state_reg <= S_RX;
                        sda_oe    <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bitc_reg == 4'h7) begin
                        state_reg <= S_RACK;
                        sda_oe    <= 1'b0;
                     end else begin
                        tx_reg   <= {tx_reg[14:0], 1'b0};
                        sda_oe   <= ~tx_reg[14];
                        bitc_reg <= bitc_reg + 4'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     mack_reg <= ~sda_sync_reg[1];
                  end else if (scl_fall) begin
                     bitc_reg <= 4'h0;
                     if (!mack_reg) begin
                        state_reg <= S_IDLE;
                     end else if (tx_byte_reg) begin
                        // a further word re-reads the same pointer
                        tx_reg      <= rd_data;
                        sda_oe      <= ~rd_data[15];
                        rd_stb      <= 1'b1;
                        tx_byte_reg <= 1'b0;
                        state_reg   <= S_TX;
                     end else begin
                        tx_reg      <= {tx_reg[14:0], 1'b0};
                        sda_oe      <= ~tx_reg[14];
                        tx_byte_reg <= 1'b1;
                        state_reg   <= S_TX;
                     end
                  end
               end
               default: begin
                  state_reg <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule // ccir_i2c_slave
`default_nettype wire

// ### rtl/ccir_top.v
// Purpose: status, fault routing, configuration and scan control registers
// Assumes: converter core events are on clk; result msb words held here
// Notes: low word of each result reads zero; core owns full-width data
`timescale 1ns/1ps
`default_nettype none
`include "ccir_consts.vh"
module ccir_top #(
   parameter [6:0] DEV_ADDR = 7'h20,
   parameter       NUM_CH   = 4
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        scl_i,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe,
   input  wire        conv_done,
   input  wire [1:0]  conv_chan,
   input  wire [11:0] conv_data,
   input  wire        timeout_evt,
   input  wire        amp_high_evt,
   input  wire        amp_low_evt,
   input  wire [1:0]  evt_chan,
   output reg         interrupt_out_n,
   output reg  [1:0]  single_channel_select,
   output reg         sleep_mode,
   output reg         activation_current_mode,
   output reg         reference_source_select,
   output reg         boosted_drive_ch0,
   output reg         multi_channel_scan_on,
   output reg  [1:0]  scan_channel_list,
   output reg  [1:0]  next_conv_channel
);
   wire [7:0]  ptr;
   wire        wr_stb;
   wire [15:0] wr_data;
   wire        rd_stb;
   reg  [15:0] rd_data;
   reg  [15:0] fault_routing_reg;
   reg  [15:0] device_config_reg;
   reg  [15:0] scan_control_reg;
   reg  [1:0]  faulting_channel_id_reg;
   reg         status_timeout_flag_reg;
   reg         status_result_ready_reg;
   reg         irq_pend_reg;
   reg  [3:0]  pending_reg;
   reg  [3:0]  result_timeout_flag_reg;
   reg  [3:0]  result_amplitude_flag_reg;
   reg  [11:0] result_msb_reg [0:3];
   reg  [1:0]  seq_last;
   wire        status_rd;
   wire        scan_on;
   wire        to_irq_evt;
   wire        rdy_irq_evt;
   wire        amp_word_evt;

   function is_data_addr;
      input [7:0] a;
      input [1:0] ch;
      begin
         is_data_addr = (a == {5'h00, ch, 1'b0});
      end
   endfunction

   ccir_i2c_slave #(
      .DEV_ADDR (DEV_ADDR)
   ) u_port (
      .clk     (clk),
      .rst     (rst),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .sda_oe  (sda_oe),
      .ptr     (ptr),
      .wr_stb  (wr_stb),
      .wr_data (wr_data),
      .rd_stb  (rd_stb),
      .rd_data (rd_data)
   );

   assign sda_o     = 1'b0;
   assign status_rd = rd_stb && (ptr == `CCIR_ADDR_STATUS);
   assign scan_on   = scan_control_reg[`CCIR_SC_SCAN_ON];

   // last channel of the repeating sequence, clipped to channel 1 on parts with fewer than four channels
   always @* begin
      case (scan_control_reg[`CCIR_SC_LIST_HI:`CCIR_SC_LIST_LO])
         2'h1:    seq_last = 2'h2;
         2'h2:    seq_last = 2'h3;
         default: seq_last = 2'h1;
      endcase
      if (NUM_CH < 4) begin
         seq_last = 2'h1;
      end
   end

   assign to_irq_evt   = timeout_evt && fault_routing_reg[`CCIR_FR_TO_IRQ];
   assign rdy_irq_evt  = conv_done && fault_routing_reg[`CCIR_FR_RDY_IRQ] &&
                         (!scan_on || conv_chan == seq_last);
   assign amp_word_evt = (amp_high_evt && fault_routing_reg[`CCIR_FR_AH_WORD]) ||
                         (amp_low_evt && fault_routing_reg[`CCIR_FR_AL_WORD]);

   always @* begin
      rd_data = 16'h0000;
      case (ptr)
         `CCIR_ADDR_STATUS: begin
            rd_data[`CCIR_ST_CHAN_HI:`CCIR_ST_CHAN_LO] = faulting_channel_id_reg;
            rd_data[`CCIR_ST_TIMEOUT] = status_timeout_flag_reg;
            rd_data[`CCIR_ST_READY]   = status_result_ready_reg;
            rd_data[3:0] = {pending_reg[0], pending_reg[1], pending_reg[2], pending_reg[3]};
         end
         `CCIR_ADDR_FAULT:  rd_data = fault_routing_reg;
         `CCIR_ADDR_CONFIG: rd_data = device_config_reg;
         `CCIR_ADDR_SCAN:   rd_data = scan_control_reg;
         default: begin
            if (ptr[7:3] == 5'h00 && !ptr[0] && ptr[2:1] < NUM_CH) begin
               rd_data[`CCIR_RW_TIMEOUT] = result_timeout_flag_reg[ptr[2:1]];
               rd_data[`CCIR_RW_AMP]     = result_amplitude_flag_reg[ptr[2:1]];
               rd_data[11:0]             = result_msb_reg[ptr[2:1]];
            end
         end
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         fault_routing_reg <= `CCIR_RST_FAULT;
         device_config_reg <= `CCIR_RST_CONFIG;
         scan_control_reg  <= `CCIR_RST_SCAN;
      end else if (wr_stb) begin
         // reserved fields are stored as written; host keeps them fixed
         case (ptr)
            `CCIR_ADDR_FAULT:  fault_routing_reg <= wr_data;
            `CCIR_ADDR_CONFIG: device_config_reg <= wr_data;
            `CCIR_ADDR_SCAN:   scan_control_reg  <= wr_data;
            default: begin
            end
         endcase
      end
   end

   // sticky flags: a new event in the clearing cycle wins
   always @(posedge clk) begin
      if (rst) begin
         faulting_channel_id_reg <= 2'h0;
         status_timeout_flag_reg <= 1'b0;
         status_result_ready_reg <= 1'b0;
         irq_pend_reg            <= 1'b0;
      end else begin
         if (status_rd || (rd_stb && is_data_addr(ptr, faulting_channel_id_reg))) begin
            status_timeout_flag_reg <= 1'b0;
         end
         if (status_rd) begin
            status_result_ready_reg <= 1'b0;
            irq_pend_reg            <= 1'b0;
         end
         if (to_irq_evt) begin
            status_timeout_flag_reg <= 1'b1;
         end
         if (rdy_irq_evt) begin
            status_result_ready_reg <= 1'b1;
         end
         if ((to_irq_evt || rdy_irq_evt) && !device_config_reg[`CCIR_CF_IRQ_OFF]) begin
            irq_pend_reg <= 1'b1;
         end
         if (to_irq_evt || amp_word_evt ||
             (timeout_evt && fault_routing_reg[`CCIR_FR_TO_WORD])) begin
            faulting_channel_id_reg <= evt_chan;
         end else if (rdy_irq_evt) begin
            faulting_channel_id_reg <= conv_chan;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_chan
         // channel number cut to the width of the channel fields
         localparam [31:0] CH_ID = g;
         always @(posedge clk) begin
            if (rst) begin
               pending_reg[g]               <= 1'b0;
               result_timeout_flag_reg[g]   <= 1'b0;
               result_amplitude_flag_reg[g] <= 1'b0;
               result_msb_reg[g]            <= 12'h000;
            end else begin
               if (rd_stb && is_data_addr(ptr, CH_ID[1:0])) begin
                  pending_reg[g]               <= 1'b0;
                  result_timeout_flag_reg[g]   <= 1'b0;
                  result_amplitude_flag_reg[g] <= 1'b0;
               end else if (status_rd && faulting_channel_id_reg == CH_ID[1:0]) begin
                  result_timeout_flag_reg[g]   <= 1'b0;
                  result_amplitude_flag_reg[g] <= 1'b0;
               end
               if (conv_done && conv_chan == CH_ID[1:0] && g < NUM_CH) begin
                  pending_reg[g]    <= 1'b1;
                  result_msb_reg[g] <= conv_data;
               end
               if (timeout_evt && evt_chan == CH_ID[1:0] && fault_routing_reg[`CCIR_FR_TO_WORD]) begin
                  result_timeout_flag_reg[g] <= 1'b1;
               end
               if (amp_word_evt && evt_chan == CH_ID[1:0]) begin
                  result_amplitude_flag_reg[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // outputs to the core, one cycle behind the register writes
   always @(posedge clk) begin
      if (rst) begin
         interrupt_out_n         <= 1'b1;
         single_channel_select   <= 2'h0;
         sleep_mode              <= 1'b1;
         activation_current_mode <= 1'b1;
         reference_source_select <= 1'b0;
         boosted_drive_ch0       <= 1'b0;
         multi_channel_scan_on   <= 1'b0;
         scan_channel_list       <= 2'h0;
         next_conv_channel       <= 2'h0;
      end else begin
         interrupt_out_n         <= ~irq_pend_reg;
         single_channel_select   <= device_config_reg[`CCIR_CF_CHAN_HI:`CCIR_CF_CHAN_LO];
         sleep_mode              <= device_config_reg[`CCIR_CF_SLEEP];
         activation_current_mode <= device_config_reg[`CCIR_CF_ACT_MODE];
         reference_source_select <= device_config_reg[`CCIR_CF_REF_SRC];
         // boost is unsafe with several channels, so scan overrides it
         boosted_drive_ch0       <= device_config_reg[`CCIR_CF_BOOST] && !scan_on;
         multi_channel_scan_on   <= scan_on;
         scan_channel_list       <= scan_control_reg[`CCIR_SC_LIST_HI:`CCIR_SC_LIST_LO];
         if (!scan_on) begin
            next_conv_channel <= device_config_reg[`CCIR_CF_CHAN_HI:`CCIR_CF_CHAN_LO];
         end else if (conv_done) begin
            next_conv_channel <= (conv_chan >= seq_last) ? 2'h0 : conv_chan + 2'h1;
         end else if (next_conv_channel > seq_last) begin
            next_conv_channel <= 2'h0;
         end
      end
   end
endmodule // ccir_top
`default_nettype wire

// ### dv/ccir_top_sva.sv
// Purpose: port-level checks of the conversion config block
// Assumes: bus clock low phase lasts longer than the update lag
// Notes: register contents are judged by the bench through the bus
`timescale 1ns/1ps
`default_nettype none
module ccir_top_sva #(
   parameter NUM_CH = 4
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       scl_i,
   input wire logic       sda_oe,
   input wire logic       conv_done,
   input wire logic       timeout_evt,
   input wire logic       interrupt_out_n,
   input wire logic [1:0] single_channel_select,
   input wire logic       sleep_mode,
   input wire logic       activation_current_mode,
   input wire logic       reference_source_select,
   input wire logic       boosted_drive_ch0,
   input wire logic       multi_channel_scan_on,
   input wire logic [1:0] scan_channel_list,
   input wire logic [1:0] next_conv_channel
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   function automatic logic [1:0] last_ch(input logic [1:0] l);
      return (l == 2'b01) ? 2'd2 : (l == 2'b10) ? 2'd3 : 2'd1;
   endfunction
   sequence s_single_settled;
      (!multi_channel_scan_on && $stable(single_channel_select)) [*3];
   endsequence
   sequence s_scan_last_done;
      multi_channel_scan_on && conv_done && (NUM_CH == 4)
         && next_conv_channel == last_ch(scan_channel_list);
   endsequence
   a_reset_outputs: assert property (disable iff (1'b0)
      rst |=> interrupt_out_n && sleep_mode && activation_current_mode && !sda_oe)
      else $error("outputs not at reset levels");
   a_boost_exclusive: assert property (
      !(boosted_drive_ch0 && multi_channel_scan_on))
      else $error("boost active during scan");
   a_single_channel: assert property (
      s_single_settled |-> next_conv_channel == single_channel_select)
      else $error("single mode channel differs from select");
   a_scan_wrap: assert property (
      s_scan_last_done |=> ##[0:1] next_conv_channel == 2'b00)
      else $error("scan did not wrap to channel 0");
   a_irq_cause: assert property (
      $fell(interrupt_out_n) |-> $past(conv_done, 2) || $past(timeout_evt, 2))
      else $error("interrupt without event");
   a_irq_release: assert property (
      $rose(interrupt_out_n) |-> !scl_i)
      else $error("interrupt released outside a bus read");
   a_mode_on_bus: assert property (
      $changed(sleep_mode) || $changed(activation_current_mode)
         || $changed(reference_source_select) |-> !scl_i)
      else $error("mode output moved without a bus write");
   a_select_on_bus: assert property (
      $changed(single_channel_select) || $changed(multi_channel_scan_on)
         || $changed(scan_channel_list) |-> !scl_i)
      else $error("channel setup moved without a bus write");
endmodule // ccir_top_sva
bind ccir_top ccir_top_sva #(.NUM_CH(NUM_CH)) chk_u (.clk(clk), .rst(rst), .scl_i(scl_i),
   .sda_oe(sda_oe), .conv_done(conv_done), .timeout_evt(timeout_evt),
   .interrupt_out_n(interrupt_out_n), .single_channel_select(single_channel_select),
   .sleep_mode(sleep_mode), .activation_current_mode(activation_current_mode),
   .reference_source_select(reference_source_select), .boosted_drive_ch0(boosted_drive_ch0),
   .multi_channel_scan_on(multi_channel_scan_on), .scan_channel_list(scan_channel_list),
   .next_conv_channel(next_conv_channel));
`default_nettype wire

// ### dv/ccir_host_model.sv
// Purpose: host side of the two-wire register port
// Assumes: lines idle high through pull-ups; clk far faster than bus
// Notes: no clock stretching, so the bus clock is never read back
`timescale 1ns/1ps
`default_nettype none
module ccir_host_model #(
   parameter logic [6:0] DEV = 7'h20,
   parameter int         Q   = 5
) (
   input  wire logic clk,
   input  wire logic sda_line,
   output var  logic scl_line,
   output var  logic sda_low
);
   initial begin
      scl_line = 1'b1;
      sda_low = 1'b0;
   end
   // one quarter bit; data moves only while clock low, else it is a start or stop
   task automatic step(input logic c, input logic l);
      scl_line <= c;
      sda_low <= l;
      repeat (Q) @(posedge clk);
   endtask
   task automatic start();
      step(1'b0, sda_low);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic stop();
      step(1'b0, sda_low);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, sda_low);
      step(1'b0, ~b);
      step(1'b1, ~b);
      r = sda_line;
      step(1'b1, ~b);
   endtask
   task automatic byte_io(input logic [7:0] v, input logic a, output logic [7:0] q,
                          output logic nak);
      for (int i = 7; i >= 0; i--)
         bit_io(v[i], q[i]);
      bit_io(a, nak);
   endtask
   task automatic wr_word(input logic [7:0] p, input logic [15:0] v, output logic ok);
      logic [7:0] q;
      logic [3:0] n;
      start();
      byte_io({DEV, 1'b0}, 1'b1, q, n[0]);
      byte_io(p, 1'b1, q, n[1]);
      byte_io(v[15:8], 1'b1, q, n[2]);
      byte_io(v[7:0], 1'b1, q, n[3]);
      stop();
      ok = (n == 4'h0);
   endtask
   task automatic rd_word(input logic [7:0] p, output logic [15:0] v);
      logic [7:0] q;
      logic       n;
      start();
      byte_io({DEV, 1'b0}, 1'b1, q, n);
      byte_io(p, 1'b1, q, n);
      start();
      byte_io({DEV, 1'b1}, 1'b1, q, n);
      byte_io(8'hFF, 1'b0, v[15:8], n);
      byte_io(8'hFF, 1'b1, v[7:0], n);
      stop();
   endtask
endmodule // ccir_host_model
`default_nettype wire

// ### dv/ccir_top_tb.sv
// Purpose: self-checking bench for the conversion config block
// Assumes: host model drives the bus; core events driven here
// Notes: random values from seed 97
`timescale 1ns/1ps
`default_nettype none
`include "ccir_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %0t: got %h exp %h", $time, g, e); end end
module ccir_top_tb;
   logic        clk, rst, conv_done, timeout_evt, amp_high_evt, amp_low_evt, ack;
   logic [1:0]  conv_chan, evt_chan;
   logic [11:0] conv_data, x;
   logic [15:0] d, w;
   wire         scl, sda_low, sda_oe, irq_n, sleep, act, ref_sel, boost, scan_on;
   wire  [1:0]  sel, list, nxt;
   wire         sda = ~(sda_low | sda_oe);
   int          bad_count = 0, num_checks = 0, cycles = 0, seed = 97, s, n;
   ccir_top #(.DEV_ADDR(7'h20), .NUM_CH(4)) dut_u (
      .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .conv_done(conv_done), .conv_chan(conv_chan), .conv_data(conv_data),
      .timeout_evt(timeout_evt), .amp_high_evt(amp_high_evt), .amp_low_evt(amp_low_evt),
      .evt_chan(evt_chan), .interrupt_out_n(irq_n), .single_channel_select(sel),
      .sleep_mode(sleep), .activation_current_mode(act), .reference_source_select(ref_sel),
      .boosted_drive_ch0(boost), .multi_channel_scan_on(scan_on),
      .scan_channel_list(list), .next_conv_channel(nxt));
   ccir_host_model #(.DEV(7'h20), .Q(5)) host_u (
      .clk(clk), .sda_line(sda), .scl_line(scl), .sda_low(sda_low));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         $display("mismatch %0t: run hung", $time);
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] v);
      host_u.wr_word(p, v, ack);
      `CHK(ack, 1'b1)
   endtask
   task automatic rd(input logic [7:0] p);
      host_u.rd_word(p, d);
   endtask
   // one-cycle core event; k 0 result, 1 timeout, 2 amp high, 3 amp low
   task automatic pulse(input int k, input logic [1:0] ch);
      x = 12'($random(seed));
      @(posedge clk);
      conv_done <= (k == 0);
      timeout_evt <= (k == 1);
      amp_high_evt <= (k == 2);
      amp_low_evt <= (k == 3);
      conv_chan <= ch;
      evt_chan <= ch;
      conv_data <= x;
      @(posedge clk);
      {conv_done, timeout_evt, amp_high_evt, amp_low_evt} <= 4'h0;
      repeat (4) @(posedge clk);
   endtask
   function automatic logic [15:0] cfg_word(input logic [15:0] r);
      return (r & 16'hEAC0) | 16'h1401;
   endfunction
   function automatic int seq_len(input logic [1:0] l);
      return (l == 2'b01) ? 3 : (l == 2'b10) ? 4 : 2;
   endfunction
   initial begin
      rst = 1'b1;
      {conv_done, timeout_evt, amp_high_evt, amp_low_evt} = 4'h0;
      conv_chan = 2'b00;
      evt_chan = 2'b00;
      conv_data = 12'h000;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK({irq_n, sleep, act, ref_sel, scan_on}, 5'b11100)
      rd(`CCIR_ADDR_CONFIG);
      `CHK(d, 16'h2801)
      rd(`CCIR_ADDR_SCAN);
      `CHK(d, 16'h020F)
      rd(`CCIR_ADDR_FAULT);
      `CHK(d, 16'h0000)
      rd(`CCIR_ADDR_STATUS);
      `CHK(d, 16'h0000)
      rd(8'h30);
      `CHK(d, 16'h0000)
      for (int i = 0; i < 4; i++) begin
         w = cfg_word((i == 0) ? 16'hFFFF : 16'($random(seed)));
         wr(`CCIR_ADDR_CONFIG, w);
         rd(`CCIR_ADDR_CONFIG);
         `CHK(d, w)
         `CHK({sel, sleep, act, ref_sel, boost}, {w[15:13], w[11], w[9], w[6]})
      end
      wr(`CCIR_ADDR_CONFIG, cfg_word(16'h0000));
      // leave scan first so every sequence starts from the single channel
      for (int l = 0; l < 4; l++) begin
         wr(`CCIR_ADDR_SCAN, 16'h020F);
         wr(`CCIR_ADDR_SCAN, {1'b1, 2'(l), 13'h020F});
         s = 0;
         n = seq_len(2'(l));
         `CHK({scan_on, list, boost, nxt}, {1'b1, 2'(l), 1'b0, 2'b00})
         for (int k = 1; k <= 5; k++) begin
            pulse(0, nxt);
            `CHK(nxt, 2'((s + k) % n))
         end
      end
      wr(`CCIR_ADDR_SCAN, 16'h020F);
      `CHK({scan_on, nxt}, 3'b000)
      wr(`CCIR_ADDR_FAULT, 16'h0000);
      pulse(1, 2'd1);
      pulse(2, 2'd1);
      pulse(0, 2'd3);
      `CHK(irq_n, 1'b1)
      rd(`CCIR_ADDR_STATUS);
      `CHK({d[11], d[6], d[0]}, 3'b001)
      rd(8'h02);
      `CHK(d[13:12], 2'b00)
      rd(8'h06);
      `CHK(d[11:0], x)
      rd(`CCIR_ADDR_STATUS);
      `CHK(d[0], 1'b0)
      wr(`CCIR_ADDR_FAULT, 16'h3821);
      pulse(1, 2'd2);
      `CHK(irq_n, 1'b0)
      rd(8'h04);
      `CHK({irq_n, d[13]}, 2'b01)
      rd(`CCIR_ADDR_STATUS);
      `CHK({irq_n, d[11]}, 2'b10)
      pulse(2, 2'd0);
      pulse(3, 2'd3);
      pulse(1, 2'd1);
      rd(`CCIR_ADDR_STATUS);
      `CHK({d[15:14], d[11]}, 3'b011)
      rd(8'h02);
      `CHK(d[13], 1'b0)
      rd(8'h06);
      `CHK(d[12], 1'b1)
      rd(8'h00);
      `CHK(d[12], 1'b1)
      pulse(0, 2'd3);
      `CHK(irq_n, 1'b0)
      rd(`CCIR_ADDR_STATUS);
      `CHK({irq_n, d[6], d[0]}, 3'b111)
      wr(`CCIR_ADDR_CONFIG, cfg_word(16'h0080));
      pulse(0, 2'd3);
      `CHK(irq_n, 1'b1)
      conclude();
   end
endmodule // ccir_top_tb
`default_nettype wire
